/* rtl/ahpc_pio_host.sv */
// Host-side ATA PIO bus cycle generator with programmable phase timing.
//
// Contract
// (RL1) Drive raises interrupt line high for attention.
// (RL2) Low IORDY stretches the active strobe.
// (RL3) IORDY is ready during ultra DMA out.
// (RL4) IORDY is drive strobe during ultra DMA in.
// (RL5) Sixteen-bit tri-stateable data bus, driven on writes.
// (RL6) Outputs change only on rising clock edge.
// (RL7) IORDY sampled on falling clock edge.
// (RL8) Read data captured on rising clock edge.
// (RL9) Address setup count precedes strobe assertion.
// (RL10) Read strobe width programmed separately from write.
// (RL11) Recovery count holds address after strobe.
// (RL12) Wait checked at programmable point after strobe.
// (RL13) Cycle length is setup plus width plus recovery.
// (RL14) Software lengthens read strobe if setup short.
// (RL15) Write data buffer enabled count after strobe.
// (RL16) Driver turn-on delayed to avoid contention.
// (RL17) Drivers turned off before drive drives again.
// (RL18) Read strobe output is the PIO read strobe.
// (RL19) Write strobe output is the PIO write strobe.
// (RL20) Bus reset low while control bit cleared.
// (RL21) Phase counts loaded into down-counters.
// (RL22) Write data held counted clocks after strobe; the code drops data_oe at recovery end if that comes first.
`timescale 1ns/1ps
`include "ahpc_regs.svh"

module ahpc_pio_host (
  input wire logic clk, // Bus clock, 200 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic bus_run, // Control bit: 1 releases the ATA bus reset.
  input wire logic [`AHPC_CNT_W-1:0] addr_setup_count, // Clocks of address setup.
  input wire logic [`AHPC_CNT_W-1:0] read_strobe_count, // Clocks of read strobe.
  input wire logic [`AHPC_CNT_W-1:0] write_strobe_count, // Clocks of write strobe.
  input wire logic [`AHPC_CNT_W-1:0] recovery_count, // Clocks of recovery.
  input wire logic [`AHPC_CNT_W-1:0] wait_sample_count, // Strobe clocks before wait check.
  input wire logic [`AHPC_CNT_W-1:0] buf_on_count, // Strobe clocks before write drive.
  input wire logic [`AHPC_CNT_W-1:0] data_hold_count, // Write data hold after strobe.
  input wire logic [`AHPC_CNT_W-1:0] buf_off_count, // Turn-around gap after driving.
  input wire logic req_valid, // PIO access request.
  output logic req_ready, // Idle; a valid request is taken this clock.
  input wire logic req_write, // 1 write, 0 read.
  input wire logic req_cs0, // Select chip select 0.
  input wire logic req_cs1, // Select chip select 1.
  input wire logic [`AHPC_ADDR_W-1:0] req_addr, // Register address.
  input wire logic [`AHPC_DATA_W-1:0] req_wdata, // Write data.
  output logic done, // One-clock pulse at cycle end.
  output logic [`AHPC_DATA_W-1:0] rd_data, // Read data of last read.
  output logic busy, // Cycle in progress.
  output logic drive_irq, // Synchronised drive interrupt level.
  output logic iordy_level, // Synchronised IORDY level.
  input wire logic drive_irq_in, // Drive interrupt pin.
  input wire logic iordy_in, // IORDY pin.
  output logic bus_reset_n, // ATA bus reset, active low.
  output logic cs0_n, // Chip select 0, active low.
  output logic cs1_n, // Chip select 1, active low.
  output logic [`AHPC_ADDR_W-1:0] addr, // Address lines.
  output logic host_read_strobe_n, // Read strobe, active low.
  output logic host_write_strobe_n, // Write strobe, active low.
  output logic dmack_n, // DMA acknowledge, held idle.
  input wire logic [`AHPC_DATA_W-1:0] data_in, // Data bus input.
  output logic [`AHPC_DATA_W-1:0] data_out, // Data bus output.
  output logic data_oe // Data bus output enable.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic iordy_s1_ff;
  logic iordy_s2_ff;
  logic irq_s1_ff;
  logic irq_s2_ff;
  logic [`AHPC_DATA_W-1:0] din_s1_ff;
  logic [`AHPC_DATA_W-1:0] din_s2_ff;

  // The falling-edge first stage plus rising-edge second gives the half-clock margin.
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      iordy_s1_ff <= 1'b1;
    end else begin
      iordy_s1_ff <= iordy_in; // RL7
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iordy_s2_ff <= 1'b1;
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
      din_s1_ff <= `AHPC_DATA_RST;
      din_s2_ff <= `AHPC_DATA_RST;
    end else begin
      iordy_s2_ff <= iordy_s1_ff; // RL12
      irq_s1_ff <= drive_irq_in;
      irq_s2_ff <= irq_s1_ff; // RL1
      din_s1_ff <= data_in; // RL8
      din_s2_ff <= din_s1_ff;
    end
  end

  assign drive_irq = irq_s2_ff;
  // A DMA engine would read this level as ready or strobe in ultra DMA bursts.
  assign iordy_level = iordy_s2_ff; // RL3 RL4

  // ----------------------------------------------------------------
  // Bus reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_reset_n <= `AHPC_BUS_RESET_ACTIVE;
    end else begin
      bus_reset_n <= bus_run; // RL20
    end
  end

  assign dmack_n = 1'b1;

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  ahpc_pkg::ahpc_state_t state_ff;
  logic write_ff;
  logic waiting_ff;
  logic [`AHPC_CNT_W-1:0] elapsed_ff;
  logic phase_load;
  logic [`AHPC_CNT_W-1:0] phase_val;
  logic phase_last;
  logic hold_load;
  logic hold_last;
  logic guard_load;
  logic guard_last;
  logic take;
  logic strobe_end;
  logic stretch;

  assign req_ready = (state_ff == ahpc_pkg::AHPC_IDLE);
  assign take = req_ready && req_valid;
  // Wait is decided at the sample point and then followed until IORDY returns high.
  assign stretch = waiting_ff ||
    ((elapsed_ff == wait_sample_count) && !iordy_s2_ff);
  assign strobe_end = (state_ff == ahpc_pkg::AHPC_STROBE) && phase_last && !stretch; // RL2
  assign busy = !req_ready;

  always_comb begin
    phase_load = 1'b0;
    phase_val = addr_setup_count;
    unique case (state_ff)
      ahpc_pkg::AHPC_IDLE: begin
        phase_load = take; // RL9
        phase_val = addr_setup_count;
      end
      ahpc_pkg::AHPC_SETUP: begin
        phase_load = phase_last;
        phase_val = write_ff ? write_strobe_count : read_strobe_count; // RL10
      end
      ahpc_pkg::AHPC_STROBE: begin
        phase_load = strobe_end;
        phase_val = recovery_count; // RL11
      end
      ahpc_pkg::AHPC_RECOVER: begin
        phase_load = 1'b0;
        phase_val = buf_off_count;
      end
      ahpc_pkg::AHPC_GUARD: begin
        phase_load = 1'b0;
        phase_val = buf_off_count;
      end
      default: begin
        phase_load = 1'b0;
        phase_val = addr_setup_count;
      end
    endcase
  end

  // Without waits a cycle is setup, width and recovery clocks back to back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ahpc_pkg::AHPC_IDLE;
    end else begin
      unique case (state_ff)
        ahpc_pkg::AHPC_IDLE: if (take) state_ff <= ahpc_pkg::AHPC_SETUP;
        ahpc_pkg::AHPC_SETUP: if (phase_last) state_ff <= ahpc_pkg::AHPC_STROBE;
        ahpc_pkg::AHPC_STROBE: if (strobe_end) state_ff <= ahpc_pkg::AHPC_RECOVER; // RL13
        ahpc_pkg::AHPC_RECOVER: begin
          if (phase_last) begin
            state_ff <= write_ff ? ahpc_pkg::AHPC_GUARD : ahpc_pkg::AHPC_IDLE;
          end
        end
        ahpc_pkg::AHPC_GUARD: if (guard_last) state_ff <= ahpc_pkg::AHPC_IDLE; // RL17
        default: state_ff <= ahpc_pkg::AHPC_IDLE;
      endcase
    end
  end

  ahpc_down_counter u_phase_cnt (
    .clk(clk),
    .rst(rst),
    .load(phase_load), // RL21
    .load_val(phase_val),
    .last(phase_last)
  );

  // ----------------------------------------------------------------
  // Strobe timing and wait tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_ff <= `AHPC_CNT_ZERO;
      waiting_ff <= 1'b0;
    end else if (state_ff != ahpc_pkg::AHPC_STROBE) begin
      elapsed_ff <= `AHPC_CNT_ZERO;
      waiting_ff <= 1'b0;
    end else begin
      if (elapsed_ff != {`AHPC_CNT_W{1'b1}}) begin
        elapsed_ff <= elapsed_ff + `AHPC_CNT_ONE;
      end
      if (iordy_s2_ff) begin
        waiting_ff <= 1'b0;
      end else if (elapsed_ff == wait_sample_count) begin
        waiting_ff <= 1'b1; // RL12
      end
    end
  end

  // ----------------------------------------------------------------
  // Address group and strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_ff <= 1'b0;
      cs0_n <= `AHPC_CS_IDLE;
      cs1_n <= `AHPC_CS_IDLE;
      addr <= `AHPC_ADDR_RST;
      data_out <= `AHPC_DATA_RST;
    end else if (take) begin
      write_ff <= req_write; // RL6
      cs0_n <= !req_cs0;
      cs1_n <= !req_cs1;
      addr <= req_addr;
      data_out <= req_wdata;
    end else if ((state_ff == ahpc_pkg::AHPC_RECOVER) && phase_last) begin
      cs0_n <= `AHPC_CS_IDLE; // RL11
      cs1_n <= `AHPC_CS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_read_strobe_n <= `AHPC_STROBE_IDLE;
      host_write_strobe_n <= `AHPC_STROBE_IDLE;
    end else if ((state_ff == ahpc_pkg::AHPC_SETUP) && phase_last) begin
      host_read_strobe_n <= write_ff; // RL18
      host_write_strobe_n <= !write_ff; // RL19
    end else if (strobe_end) begin
      host_read_strobe_n <= `AHPC_STROBE_IDLE;
      host_write_strobe_n <= `AHPC_STROBE_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Read capture and completion
  // ----------------------------------------------------------------
  // Data is taken through the synchroniser, so the sample is two clocks before release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= `AHPC_DATA_RST;
    end else if (strobe_end && !write_ff) begin
      rd_data <= din_s2_ff; // RL8
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= (state_ff == ahpc_pkg::AHPC_RECOVER) && phase_last;
    end
  end

  // ----------------------------------------------------------------
  // Data bus driver control
  // ----------------------------------------------------------------
  assign hold_load = strobe_end;
  assign guard_load = (state_ff == ahpc_pkg::AHPC_RECOVER) && phase_last;

  ahpc_down_counter u_hold_cnt (
    .clk(clk),
    .rst(rst),
    .load(hold_load),
    .load_val(data_hold_count),
    .last(hold_last)
  );

  ahpc_down_counter u_guard_cnt (
    .clk(clk),
    .rst(rst),
    .load(guard_load),
    .load_val(buf_off_count),
    .last(guard_last)
  );

  // Turn-on waits for the drive to leave the bus; turn-off ends at hold or recovery end.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_oe <= 1'b0; // RL5
    end else if (!write_ff) begin
      data_oe <= 1'b0;
    end else if ((state_ff == ahpc_pkg::AHPC_STROBE) && (elapsed_ff == buf_on_count)) begin
      data_oe <= 1'b1; // RL15 RL16
    end else if ((state_ff == ahpc_pkg::AHPC_RECOVER) && (hold_last || phase_last)) begin
      data_oe <= 1'b0; // RL22 RL17
    end
  end

endmodule : ahpc_pio_host

/* rtl/ahpc_regs.svh */
// Widths, reset values and fixed figures of the host ATA PIO cycle generator.
`ifndef AHPC_REGS_SVH
`define AHPC_REGS_SVH

`define AHPC_CNT_W 8
`define AHPC_DATA_W 16
`define AHPC_ADDR_W 3
`define AHPC_CNT_ONE 8'h01
`define AHPC_CNT_ZERO 8'h00
`define AHPC_DATA_RST 16'h0000
`define AHPC_ADDR_RST 3'h0
`define AHPC_STROBE_IDLE 1'b1
`define AHPC_CS_IDLE 1'b1
`define AHPC_BUS_RESET_ACTIVE 1'b0

`endif

/* rtl/ahpc_pkg.sv */
// Types shared by the host ATA PIO cycle generator.
package ahpc_pkg;

  typedef enum logic [4:0] {
    AHPC_IDLE    = 5'h01,
    AHPC_SETUP   = 5'h02,
    AHPC_STROBE  = 5'h04,
    AHPC_RECOVER = 5'h08,
    AHPC_GUARD   = 5'h10
  } ahpc_state_t;

endpackage : ahpc_pkg

/* rtl/ahpc_down_counter.sv */
// Loadable down-counter that times one bus cycle phase.
`timescale 1ns/1ps
`include "ahpc_regs.svh"

module ahpc_down_counter (
  input wire logic clk, // Bus clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic load, // Start a phase.
  input wire logic [`AHPC_CNT_W-1:0] load_val, // Phase length in clocks.
  output logic last // Current clock is the phase's last (or counter idle).
);

  logic [`AHPC_CNT_W-1:0] cnt_ff;

  // A zero count is taken as one clock so every phase is at least one period wide.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= `AHPC_CNT_ZERO;
    end else if (load) begin
      cnt_ff <= (load_val == `AHPC_CNT_ZERO) ? `AHPC_CNT_ONE : load_val;
    end else if (cnt_ff != `AHPC_CNT_ZERO) begin
      cnt_ff <= cnt_ff - `AHPC_CNT_ONE;
    end
  end

  assign last = (cnt_ff <= `AHPC_CNT_ONE);

endmodule : ahpc_down_counter

/* test/ahpc_pio_host_assertions.sv */
// Port timing checker of the ATA PIO host cycle generator.
`timescale 1ns/1ps
module ahpc_pio_host_chk (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic bus_run, // Run bit.
  input wire logic [7:0] addr_setup_count, // Setup.
  input wire logic [7:0] read_strobe_count, // Read width.
  input wire logic [7:0] write_strobe_count, // Write width.
  input wire logic [7:0] recovery_count, // Recovery.
  input wire logic [7:0] buf_on_count, // Drive on.
  input wire logic [7:0] data_hold_count, // Hold.
  input wire logic req_valid, // Request.
  input wire logic req_ready, // Ready.
  input wire logic done, // End pulse.
  input wire logic busy, // Busy.
  input wire logic iordy_level, // Wait level.
  input wire logic bus_reset_n, // Bus reset.
  input wire logic host_read_strobe_n, // Read strobe.
  input wire logic host_write_strobe_n, // Write strobe.
  input wire logic data_oe // Drive enable.
);
  // ----------------------------------------
  // Position within the cycle
  // ----------------------------------------
  function automatic logic [9:0] one_min(input logic [7:0] v);
    return (v == 8'h00) ? 10'h001 : {2'h0, v};
  endfunction : one_min
  logic [9:0] cyc_ff;
  logic [9:0] end_ff;
  logic stall_ff;
  wire [9:0] su = one_min(addr_setup_count);
  wire [9:0] rc = one_min(recovery_count);
  wire [9:0] hd = (one_min(data_hold_count) < rc) ? one_min(data_hold_count) : rc;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_ff <= 10'h000;
      stall_ff <= 1'b0;
    end else if (req_valid && req_ready) begin
      cyc_ff <= 10'h000;
      stall_ff <= 1'b0;
    end else if (busy) begin
      cyc_ff <= cyc_ff + 10'h001;
      stall_ff <= stall_ff || !iordy_level;
    end
  end
  // Edge that releases the strobe, so recovery stays exact even after waits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      end_ff <= 10'h000;
    end else if (!host_read_strobe_n || !host_write_strobe_n) begin
      end_ff <= cyc_ff + 10'h001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  setup_len_a: assert property (
    $fell(host_read_strobe_n) || $fell(host_write_strobe_n) |-> cyc_ff == su)
    else $error("Strobe asserted after wrong setup.");
  read_width_a: assert property (
    $rose(host_read_strobe_n) && !stall_ff |-> cyc_ff == su + one_min(read_strobe_count))
    else $error("Read strobe width wrong.");
  write_width_a: assert property (
    $rose(host_write_strobe_n) && !stall_ff |-> cyc_ff == su + one_min(write_strobe_count))
    else $error("Write strobe width wrong.");
  recovery_a: assert property ($rose(done) |-> cyc_ff == end_ff + rc)
    else $error("Recovery length wrong.");
  done_pulse_a: assert property (done |=> !done)
    else $error("Done longer than one clock.");
  wait_hold_a: assert property (
    !host_read_strobe_n && !iordy_level && stall_ff |=> !host_read_strobe_n)
    else $error("Strobe released during wait.");
  oe_on_a: assert property (
    $rose(data_oe) |-> cyc_ff == su + {2'h0, buf_on_count} + 10'h001)
    else $error("Data drive on at wrong clock.");
  oe_off_a: assert property ($fell(data_oe) |-> cyc_ff == end_ff + hd)
    else $error("Data drive off at wrong clock.");
  oe_read_a: assert property (!host_read_strobe_n |-> !data_oe)
    else $error("Host drives bus during read.");
  reset_out_a: assert property (!bus_run |=> !bus_reset_n)
    else $error("Bus reset not held.");
endmodule : ahpc_pio_host_chk

bind ahpc_pio_host ahpc_pio_host_chk u_chk (.clk, .rst, .bus_run, .addr_setup_count,
  .read_strobe_count, .write_strobe_count, .recovery_count, .buf_on_count,
  .data_hold_count, .req_valid, .req_ready, .done, .busy, .iordy_level, .bus_reset_n,
  .host_read_strobe_n, .host_write_strobe_n, .data_oe);

/* test/ahpc_drive_model.sv */
// Behavioural drive: register file, wait states and interrupt line.
`timescale 1ns/1ps
module ahpc_drive_model (
  input wire logic clk, // Clock.
  input wire logic cs0_n, // Select 0.
  input wire logic cs1_n, // Select 1.
  input wire logic [2:0] addr, // Address.
  input wire logic host_read_strobe_n, // Read strobe.
  input wire logic host_write_strobe_n, // Write strobe.
  input wire logic [15:0] data_out, // Host data.
  input wire logic data_oe, // Host drives.
  input wire logic [7:0] wait_cycles, // Wait length.
  input wire logic irq_req, // Raise interrupt.
  output logic [15:0] data_in, // Bus level.
  output logic iordy_in, // Wait pin.
  output logic drive_irq_in // Interrupt pin.
);
  // ----------------------------------------
  // Drive side
  // ----------------------------------------
  logic [15:0] regs [0:15];
  logic [15:0] junk = 16'h5A5A;
  logic [7:0] hold = 8'h00;
  logic sel_q = 1'b0;
  wire sel = !cs0_n || !cs1_n;
  // A released bus toggles every clock so stale data can never pass as read data.
  always @(posedge clk) begin
    junk <= ~junk;
    sel_q <= sel;
    if (sel && !sel_q) begin
      hold <= wait_cycles;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
  always @(posedge host_write_strobe_n) begin
    if (sel) begin
      regs[{cs1_n, addr}] <= data_in;
    end
  end
  assign data_in = data_oe ? data_out : ((!host_read_strobe_n && sel) ? regs[{cs1_n, addr}] : junk);
  assign iordy_in = (hold == 8'h00);
  assign drive_irq_in = irq_req;
endmodule : ahpc_drive_model

/* test/ahpc_pio_host_bench.sv */
// Self-checking bench of the ATA PIO host cycle generator.
`timescale 1ns/1ps
module ahpc_pio_host_bench;
  logic clk, rst, bus_run, req_valid, req_ready, req_write, req_cs0, req_cs1, irq_req;
  logic done, busy, drive_irq, iordy_level, drive_irq_in, iordy_in, bus_reset_n;
  logic cs0_n, cs1_n, host_read_strobe_n, host_write_strobe_n, data_oe, dmack_n;
  logic [7:0] addr_setup_count, read_strobe_count, write_strobe_count, recovery_count;
  logic [7:0] wait_sample_count, buf_on_count, data_hold_count, buf_off_count, wait_cycles;
  logic [2:0] req_addr, addr;
  logic [15:0] req_wdata, rd_data, data_in, data_out;
  int errors, num_checks, ticks, len;
  ahpc_pio_host u_dut (.clk, .rst, .bus_run, .addr_setup_count, .read_strobe_count,
    .write_strobe_count, .recovery_count, .wait_sample_count, .buf_on_count,
    .data_hold_count, .buf_off_count, .req_valid, .req_ready, .req_write, .req_cs0,
    .req_cs1, .req_addr, .req_wdata, .done, .rd_data, .busy, .drive_irq, .iordy_level,
    .drive_irq_in, .iordy_in, .bus_reset_n, .cs0_n, .cs1_n, .addr, .host_read_strobe_n,
    .host_write_strobe_n, .dmack_n, .data_in, .data_out, .data_oe);
  ahpc_drive_model u_drive (.clk, .cs0_n, .cs1_n, .addr, .host_read_strobe_n,
    .host_write_strobe_n, .data_out, .data_oe, .wait_cycles, .irq_req, .data_in,
    .iordy_in, .drive_irq_in);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic counts(input logic [7:0] s, rd, wr, rc, on);
    addr_setup_count = s;
    read_strobe_count = rd;
    write_strobe_count = wr;
    recovery_count = rc;
    buf_on_count = on;
    data_hold_count = on;
    buf_off_count = on;
  endtask : counts
  // Holds the request until taken; len ends as clocks from take to done.
  // It returns one clock after done, so count changes never land inside a cycle.
  task automatic pio(input logic wr, input logic c1, input logic [2:0] a, input logic [15:0] d);
    req_write = wr;
    req_cs0 = !c1;
    req_cs1 = c1;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    len = 0;
    while (!req_ready && len < 50) begin
      @(negedge clk);
      len++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    len = 0;
    while (!done && len < 300) begin
      @(negedge clk);
      len++;
    end
    chk("cycle done", 16'h0001, {15'h0000, done});
    @(negedge clk);
  endtask : pio
  task automatic t_reset;
    chk("idle pins", 16'h019E, {7'h00, dmack_n, req_ready, busy, bus_reset_n,
      host_read_strobe_n, host_write_strobe_n, cs0_n, cs1_n, data_oe});
    bus_run = 1'b1;
    repeat (2) @(negedge clk);
    chk("bus reset run", 16'h0001, {15'h0000, bus_reset_n});
    bus_run = 1'b0;
    repeat (2) @(negedge clk);
    chk("bus reset stop", 16'h0000, {15'h0000, bus_reset_n});
    bus_run = 1'b1;
  endtask : t_reset
  task automatic t_access;
    pio(1'b1, 1'b0, 3'h5, 16'hA55A);
    chk("write length", 16'h000A, 16'(len));
    pio(1'b0, 1'b0, 3'h5, 16'h0000);
    chk("read length", 16'h0009, 16'(len));
    chk("read data", 16'hA55A, rd_data);
    pio(1'b1, 1'b1, 3'h5, 16'h3CC3);
    pio(1'b0, 1'b1, 3'h5, 16'h0000);
    chk("select one data", 16'h3CC3, rd_data);
    pio(1'b0, 1'b0, 3'h5, 16'h0000);
    chk("select zero data", 16'hA55A, rd_data);
  endtask : t_access
  task automatic t_zero;
    counts(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    pio(1'b0, 1'b0, 3'h6, 16'h0000);
    chk("minimum length", 16'h0003, 16'(len));
    // A one-clock write strobe leaves no data setup, so software widens it.
    counts(8'h00, 8'h00, 8'h02, 8'h00, 8'h00);
    pio(1'b1, 1'b0, 3'h6, 16'h1234);
    chk("short write length", 16'h0004, 16'(len));
    counts(8'h02, 8'h04, 8'h05, 8'h03, 8'h01);
    pio(1'b0, 1'b0, 3'h6, 16'h0000);
    chk("minimum write data", 16'h1234, rd_data);
  endtask : t_zero
  task automatic t_wait;
    wait_cycles = 8'h08;
    pio(1'b0, 1'b0, 3'h5, 16'h0000);
    wait_cycles = 8'h00;
    chk("read stretched", 16'h0001, 16'(len > 9));
    chk("stretched data", 16'hA55A, rd_data);
    chk("wait released", 16'h0001, {15'h0000, iordy_level});
  endtask : t_wait
  task automatic t_irq;
    irq_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq raised", 16'h0001, {15'h0000, drive_irq});
    irq_req = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq dropped", 16'h0000, {15'h0000, drive_irq});
  endtask : t_irq
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    bus_run = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cs0 = 1'b0;
    req_cs1 = 1'b0;
    req_addr = 3'h0;
    req_wdata = 16'h0000;
    irq_req = 1'b0;
    wait_cycles = 8'h00;
    wait_sample_count = 8'h02;
    counts(8'h02, 8'h04, 8'h05, 8'h03, 8'h01);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_access();
    t_zero();
    t_wait();
    t_irq();
    tally_and_finish();
  end
endmodule : ahpc_pio_host_bench
